// ===== hw/lwf_defines.svh
// constants of the low-rate packet framer: framing, timing, commands
`ifndef LWF_DEFINES_SVH
`define LWF_DEFINES_SVH

// ****************************************
// framing
// ****************************************
`define LWF_PRE_BYTE    8'h00
`define LWF_PRE_LAST    7'h03
`define LWF_SFD         8'hA7
`define LWF_MAX_PAY     7'h7D
`define LWF_FCS_LEN     7'h02
`define LWF_MIN_LEN     7'h02
`define LWF_CRC_POLY    16'h8408
`define LWF_CRC_INIT    16'h0000
`define LWF_LEN_ADDR    7'h00
`define LWF_LQI_ADDR    7'h7F

// ****************************************
// timing
// ****************************************
`define LWF_CLK_MHZ     125
`define LWF_CLK_NS      8
`define LWF_LQI_TIME_US 64
`define LWF_LQI_CYCLES  (`LWF_LQI_TIME_US * `LWF_CLK_MHZ)
`define LWF_CCA_TIME_NS 16384
`define LWF_CCA_CYCLES  (`LWF_CCA_TIME_NS / `LWF_CLK_NS)
`define LWF_CCA_SHIFT   11
`define LWF_CCA_OFFSET  8'h07

// ****************************************
// host commands (first byte of a select frame)
// ****************************************
`define LWF_CMD_WR_CFG  8'h01
`define LWF_CMD_WR_TXB  8'h02
`define LWF_CMD_TX_GO   8'h03
`define LWF_CMD_RD_RXB  8'h04
`define LWF_CMD_RD_STAT 8'h05
`define LWF_CMD_CCA     8'h06
`define LWF_CMD_RD_CCA  8'h07
`define LWF_CMD_STR_WR  8'h08

// ****************************************
// status byte bit positions and reset values
// ****************************************
`define LWF_ST_RXDONE   0
`define LWF_ST_RXWORD   1
`define LWF_ST_TXDONE   2
`define LWF_ST_TXREQ    3
`define LWF_ST_CCADONE  4
`define LWF_ST_CRCOK    5
`define LWF_ST_STREAM   6
`define LWF_STAT_RST    5'h00
`define LWF_CHAN_RST    4'h0

`endif

// ===== hw/lwf_pkg.sv
// types of the low-rate packet framer
package lwf_pkg;
   typedef enum logic {MODE_PACKET, MODE_STREAM} lwf_mode_t;
   typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_PAY,
                             TX_FCS_LO, TX_FCS_HI, TX_DRAIN} lwf_tx_t;
   typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_DATA} lwf_rx_t;
endpackage

// ===== hw/lwf_framer.sv
// low-rate wireless packet framer: spi host port, framing, crc, lqi, cca
`timescale 1ns/1ns
`include "lwf_defines.svh"

module lwf_framer #(
   parameter int LQI_CYCLES = `LWF_LQI_CYCLES
) (
   // core clock and reset
   input  wire logic       core_clk,
   input  wire logic       nrst,
   // spi link from host
   input  wire logic       spiClk,
   input  wire logic       spiSelN,
   input  wire logic       spiMosi,
   output logic            spiMisoOut,
   output logic            spiMisoOe,
   output logic            irqN,
   // modem side
   output logic            modemTxValid,
   output logic [7:0]      modemTxData,
   input  wire logic       modemTxReady,
   input  wire logic       modemRxValid,
   input  wire logic [7:0] modemRxData,
   input  wire logic [7:0] modemEnergy,
   output logic [3:0]      modemChannel
);
   // ********************************************
   // declarations
   // ********************************************
   logic [2:0]  bitCnt;
   logic [7:0]  shiftIn, spiWord, misoShift, txHold, streamHold;
   logic        spiTog, togS1, togS2, togS3, selS1, selS2, spiRstN;
   logic        byteEvt, haveCmd, streamFull, txStart, ccaStart;
   logic [7:0]  cmd;
   logic [6:0]  wrPtr, rdPtr, txLen, txCnt, rxIdx, rxLen;
   lwf_pkg::lwf_mode_t mode;
   lwf_pkg::lwf_tx_t   txState;
   lwf_pkg::lwf_rx_t   rxState;
   logic [15:0] txCrc, rxCrc;
   logic        txValid, push, pop, inReady, crcOk, rxStart;
   logic [7:0]  txData, ent0, ent1, rxRdData, lqi, lqiPeak, ccaLevel;
   logic [1:0]  fifoCnt;
   logic [13:0] lqiCnt;
   logic [11:0] ccaCnt;
   logic [18:0] ccaSum, next_ccaSum;
   logic        ccaRun, txDoneEvt, txReqEvt, rxWordEvt, rxDoneEvt;
   logic        ccaDoneEvt, statClr;
   logic [4:0]  status, next_status, statSet;
   logic [7:0]  txRam [0:127];
   logic [7:0]  rxRam [0:127];

   // reflected crc-16 over one byte, lsb first
   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ `LWF_CRC_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   // ********************************************
   // spi link domain
   // ********************************************
   // deselect clears the shifter; the link clock stops between frames
   assign spiRstN = nrst & ~spiSelN;

   // mosi sampled on the rising edge, msb first
   always_ff @(posedge spiClk or negedge spiRstN) begin
      if (!spiRstN) begin
         bitCnt  <= 3'h0;
         shiftIn <= 8'h00;
      end else begin
         bitCnt  <= bitCnt + 3'h1;
         shiftIn <= {shiftIn[6:0], spiMosi};
      end
   end

   // whole byte handed to the core by a toggle; word holds 8 edges
   always_ff @(posedge spiClk or negedge nrst) begin
      if (!nrst) begin
         spiWord <= 8'h00;
         spiTog  <= 1'b0;
      end else if (bitCnt == 3'h7) begin
         spiWord <= {shiftIn[6:0], spiMosi};
         spiTog  <= ~spiTog;
      end
   end

   // miso shifted on the falling edge; txHold is quiet at byte start
   always_ff @(negedge spiClk or negedge spiRstN) begin
      if (!spiRstN) begin
         misoShift <= 8'h00;
         spiMisoOe <= 1'b0;
      end else begin
         misoShift <= (bitCnt == 3'h0) ? txHold : {misoShift[6:0], 1'b0};
         spiMisoOe <= 1'b1;
      end
   end
   assign spiMisoOut = misoShift[7];

   // ********************************************
   // crossing into the core
   // ********************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         togS1 <= 1'b0;
         togS2 <= 1'b0;
         togS3 <= 1'b0;
         selS1 <= 1'b1;
         selS2 <= 1'b1;
      end else begin
         togS1 <= spiTog;
         togS2 <= togS1;
         togS3 <= togS2;
         selS1 <= spiSelN;
         selS2 <= selS1;
      end
   end
   assign byteEvt = togS2 ^ togS3;
   assign statClr = byteEvt && !haveCmd && spiWord == `LWF_CMD_RD_STAT;

   // ********************************************
   // host command decoder
   // ********************************************
   // first byte of a frame is the command, later bytes its data
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         haveCmd  <= 1'b0;
         cmd      <= 8'h00;
         mode     <= lwf_pkg::MODE_PACKET;
         modemChannel <= `LWF_CHAN_RST;
         wrPtr    <= 7'h00;
         txLen    <= 7'h00;
         txHold   <= 8'h00;
         txStart  <= 1'b0;
         ccaStart <= 1'b0;
      end else begin
         txStart  <= 1'b0;
         ccaStart <= 1'b0;
         if (selS2) begin
            haveCmd <= 1'b0;
         end else if (byteEvt && !haveCmd) begin
            haveCmd <= 1'b1;
            cmd     <= spiWord;
            wrPtr   <= 7'h00;
            ccaStart <= spiWord == `LWF_CMD_CCA;
            if (spiWord == `LWF_CMD_RD_STAT) begin
               txHold <= {1'b0, mode, crcOk, status};
            end else if (spiWord == `LWF_CMD_RD_CCA) begin
               txHold <= ccaLevel;
            end else if (spiWord == `LWF_CMD_RD_RXB) begin
               // packet reads always open on the length byte
               txHold <= (mode == lwf_pkg::MODE_PACKET) ?
                         rxRam[`LWF_LEN_ADDR] : rxRdData;
            end
         end else if (byteEvt) begin
            if (cmd == `LWF_CMD_WR_CFG) begin
               mode <= lwf_pkg::lwf_mode_t'(spiWord[0]);
               modemChannel <= spiWord[7:4];
            end else if (cmd == `LWF_CMD_WR_TXB) begin
               if (wrPtr < `LWF_MAX_PAY) begin
                  wrPtr <= wrPtr + 7'h01;
               end
            end else if (cmd == `LWF_CMD_TX_GO) begin
               txLen   <= (spiWord[6:0] > `LWF_MAX_PAY || spiWord[7]) ?
                          `LWF_MAX_PAY : spiWord[6:0];
               txStart <= 1'b1;
            end else if (cmd == `LWF_CMD_RD_RXB) begin
               txHold <= rxRdData;
            end
         end
      end
   end

   // transmit buffer is written by the host only
   always_ff @(posedge core_clk) begin
      if (byteEvt && haveCmd && !selS2 && cmd == `LWF_CMD_WR_TXB &&
          wrPtr < `LWF_MAX_PAY) begin
         txRam[wrPtr] <= spiWord;
      end
   end

   // rx read pointer restarts per frame and per packet read command
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdPtr <= 7'h00;
      end else if (rxStart) begin
         rdPtr <= `LWF_LEN_ADDR;
      end else if (byteEvt && !selS2 && (haveCmd || spiWord ==
                   `LWF_CMD_RD_RXB) && (haveCmd ? cmd : spiWord) ==
                   `LWF_CMD_RD_RXB) begin
         rdPtr <= (!haveCmd && mode == lwf_pkg::MODE_PACKET) ?
                  `LWF_LEN_ADDR + 7'h01 : rdPtr + 7'h01;
      end
   end
   assign rxRdData = (rdPtr == `LWF_LQI_ADDR) ? lqi : rxRam[rdPtr];

   // stream word slot; a new word beats the take in the same cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         streamFull <= 1'b0;
         streamHold <= 8'h00;
      end else if (byteEvt && haveCmd && !selS2 &&
                   cmd == `LWF_CMD_STR_WR) begin
         streamFull <= 1'b1;
         streamHold <= spiWord;
      end else if (push && txState == lwf_pkg::TX_PAY &&
                   mode == lwf_pkg::MODE_STREAM) begin
         streamFull <= 1'b0;
      end
   end

   // ********************************************
   // transmit framer
   // ********************************************
   always_comb begin
      txValid = 1'b1;
      case (txState)
         lwf_pkg::TX_PRE:    txData = `LWF_PRE_BYTE;
         lwf_pkg::TX_SFD:    txData = `LWF_SFD;
         lwf_pkg::TX_LEN: txData = {1'b0, txLen + `LWF_FCS_LEN};
         lwf_pkg::TX_PAY: begin
            txData  = (mode == lwf_pkg::MODE_STREAM) ? streamHold :
                      txRam[txCnt];
            txValid = mode == lwf_pkg::MODE_PACKET || streamFull;
         end
         lwf_pkg::TX_FCS_LO: txData = txCrc[7:0];
         lwf_pkg::TX_FCS_HI: txData = txCrc[15:8];
         default: begin
            txData  = 8'h00;
            txValid = 1'b0;
         end
      endcase
   end
   assign push = txValid && inReady;

   // states from preamble to fcs advance only on an accepted byte, so a stall holds them
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         txState <= lwf_pkg::TX_IDLE;
         txCnt   <= 7'h00;
         txCrc   <= `LWF_CRC_INIT;
      end else begin
         case (txState)
            lwf_pkg::TX_IDLE: begin
               txCnt <= 7'h00;
               txCrc <= `LWF_CRC_INIT;
               if (txStart) begin
                  txState <= lwf_pkg::TX_PRE;
               end
            end
            lwf_pkg::TX_PRE: if (push) begin
               txCnt <= txCnt + 7'h01;
               if (txCnt == `LWF_PRE_LAST) begin
                  txState <= lwf_pkg::TX_SFD;
                  txCnt   <= 7'h00;
               end
            end
            lwf_pkg::TX_SFD: if (push) begin
               txState <= lwf_pkg::TX_LEN;
            end
            lwf_pkg::TX_LEN: if (push) begin
               txState <= (txLen == 7'h00) ? lwf_pkg::TX_FCS_LO :
                          lwf_pkg::TX_PAY;
            end
            lwf_pkg::TX_PAY: if (push) begin
               txCrc <= crc_upd(txCrc, txData);
               txCnt <= txCnt + 7'h01;
               if (txCnt == txLen - 7'h01) begin
                  txState <= lwf_pkg::TX_FCS_LO;
               end
            end
            lwf_pkg::TX_FCS_LO: if (push) begin
               txState <= lwf_pkg::TX_FCS_HI;
            end
            lwf_pkg::TX_FCS_HI: if (push) begin
               txState <= lwf_pkg::TX_DRAIN;
            end
            default: if (!modemTxValid) begin
               txState <= lwf_pkg::TX_IDLE;
            end
         endcase
      end
   end
   assign txDoneEvt = txState == lwf_pkg::TX_DRAIN && !modemTxValid;
   assign txReqEvt  = mode == lwf_pkg::MODE_STREAM && push &&
                      ((txState == lwf_pkg::TX_LEN && txLen != 7'h00) ||
                       (txState == lwf_pkg::TX_PAY && txCnt != txLen - 7'h01));

   // ********************************************
   // two-entry buffer toward the modem
   // ********************************************
   // ent0 is the head and drives the modem directly from a flop
   assign pop     = modemTxValid && modemTxReady;
   assign inReady = fifoCnt != 2'h2;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fifoCnt      <= 2'h0;
         ent0         <= 8'h00;
         ent1         <= 8'h00;
         modemTxValid <= 1'b0;
      end else begin
         fifoCnt      <= fifoCnt + {1'b0, push} - {1'b0, pop};
         modemTxValid <= (fifoCnt + {1'b0, push} - {1'b0, pop}) != 2'h0;
         if (pop) begin
            ent0 <= (fifoCnt == 2'h2) ? ent1 : txData;
         end else if (push && fifoCnt == 2'h0) begin
            ent0 <= txData;
         end
         if (push && ((fifoCnt == 2'h1 && !pop) || fifoCnt == 2'h2)) begin
            ent1 <= txData;
         end
      end
   end
   assign modemTxData = ent0;

   // ********************************************
   // receive parser
   // ********************************************
   assign rxStart = modemRxValid && rxState == lwf_pkg::RX_HUNT &&
                    modemRxData == `LWF_SFD;
   assign rxDoneEvt = modemRxValid && rxState == lwf_pkg::RX_DATA &&
                      rxIdx == rxLen;
   assign rxWordEvt = modemRxValid && rxState == lwf_pkg::RX_DATA &&
                      mode == lwf_pkg::MODE_STREAM &&
                      rxIdx <= rxLen - `LWF_FCS_LEN;

   // preamble bytes are skipped until the delimiter shows up
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rxState <= lwf_pkg::RX_HUNT;
         rxIdx   <= 7'h00;
         rxLen   <= 7'h00;
         rxCrc   <= `LWF_CRC_INIT;
         crcOk   <= 1'b0;
      end else if (modemRxValid) begin
         case (rxState)
            lwf_pkg::RX_HUNT: if (rxStart) begin
               rxState <= lwf_pkg::RX_LEN;
            end
            lwf_pkg::RX_LEN: begin
               rxLen   <= modemRxData[6:0];
               rxIdx   <= 7'h01;
               rxCrc   <= `LWF_CRC_INIT;
               rxState <= (modemRxData[7] || modemRxData[6:0] <
                          `LWF_MIN_LEN) ? lwf_pkg::RX_HUNT : lwf_pkg::RX_DATA;
            end
            default: begin
               rxCrc <= crc_upd(rxCrc, modemRxData);
               rxIdx <= rxIdx + 7'h01;
               if (rxIdx == rxLen) begin
                  crcOk   <= crc_upd(rxCrc, modemRxData) == 16'h0000;
                  rxState <= lwf_pkg::RX_HUNT;
               end
            end
         endcase
      end
   end

   // length, payload and received fcs land in the rx ram
   always_ff @(posedge core_clk) begin
      if (modemRxValid && rxState == lwf_pkg::RX_LEN) begin
         rxRam[`LWF_LEN_ADDR] <= modemRxData;
      end else if (modemRxValid && rxState == lwf_pkg::RX_DATA) begin
         rxRam[rxIdx] <= modemRxData;
      end
   end

   // link quality is the peak energy seen in the window after preamble
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lqiCnt  <= 14'h0000;
         lqiPeak <= 8'h00;
         lqi     <= 8'h00;
      end else if (rxStart) begin
         lqiCnt  <= 14'(LQI_CYCLES);
         lqiPeak <= modemEnergy;
      end else if (lqiCnt != 14'h0000) begin
         lqiCnt  <= lqiCnt - 14'h0001;
         lqiPeak <= (modemEnergy > lqiPeak) ? modemEnergy : lqiPeak;
         if (lqiCnt == 14'h0001) begin
            lqi <= lqiPeak;
         end
      end
   end

   // ********************************************
   // clear channel assessment
   // ********************************************
   // mean energy over the window; saturating add of the fixed offset
   assign next_ccaSum = ccaSum + {11'h000, modemEnergy};
   assign ccaDoneEvt  = ccaRun && ccaCnt == 12'(`LWF_CCA_CYCLES - 1);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ccaRun   <= 1'b0;
         ccaCnt   <= 12'h000;
         ccaSum   <= 19'h00000;
         ccaLevel <= 8'h00;
      end else if (ccaStart && !ccaRun) begin
         ccaRun <= 1'b1;
         ccaCnt <= 12'h000;
         ccaSum <= 19'h00000;
      end else if (ccaRun) begin
         ccaSum <= next_ccaSum;
         ccaCnt <= ccaCnt + 12'h001;
         if (ccaDoneEvt) begin
            ccaRun   <= 1'b0;
            ccaLevel <= (next_ccaSum[18:11] > 8'hFF - `LWF_CCA_OFFSET) ?
               8'hFF : next_ccaSum[18:11] + `LWF_CCA_OFFSET;
         end
      end
   end

   // ********************************************
   // status and interrupt
   // ********************************************
   assign statSet = {ccaDoneEvt, txReqEvt, txDoneEvt,
                     rxWordEvt, rxDoneEvt};
   assign next_status = (status & {5{~statClr}}) | statSet;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         status <= `LWF_STAT_RST;
         irqN   <= 1'b1;
      end else begin
         status <= next_status;
         irqN   <= ~|next_status;
      end
   end

   // ********************************************
   // checks
   // ********************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // a status read with no new event must release the interrupt line
   a_irq_clear: assert property (
      statClr && statSet == 5'h00 |=> irqN && status == 5'h00)
      else $error("interrupt not released by status read");
   a_len_field_sum: assert property (
      push && txState == lwf_pkg::TX_LEN |->
      txData == 8'(txLen) + 8'h02 && txData <= 8'h7F)
      else $error("length field is not payload plus two");
   a_sfd_after_pre: assert property (
      push && txState == lwf_pkg::TX_SFD |->
      txData == 8'hA7 && $past(txState, 1) != lwf_pkg::TX_IDLE)
      else $error("delimiter byte wrong");
   a_start_to_pre: assert property (
      $rose(txStart) && txState == lwf_pkg::TX_IDLE |=>
      ##1 txState == lwf_pkg::TX_PRE)
      else $error("transmit did not start with preamble");
   a_pay_limit: assert property (txLen <= 7'h7D)
      else $error("payload length above limit");
   a_rx_done_flag: assert property (
      rxDoneEvt |=> status[0] && !irqN)
      else $error("receive completion not flagged");
   a_word_irq: assert property (
      rxWordEvt |=> status[1] ##0 !irqN)
      else $error("stream word without interrupt");
   a_pkt_no_word: assert property (
      mode == lwf_pkg::MODE_PACKET |=> !$rose(status[1]))
      else $error("word flag raised in packet mode");
   // drain time depends on the modem, so check the flag at the event
   a_tx_done_irq: assert property (
      txDoneEvt |=> status[2] && !irqN && txState == lwf_pkg::TX_IDLE)
      else $error("transmit completion not raised");
   a_cca_offset: assert property (ccaDoneEvt |=> ccaLevel >= 8'h07)
      else $error("cca level lacks offset");
   a_stall_hold: assert property (modemTxValid && !modemTxReady |=>
      modemTxValid && $stable(modemTxData))
      else $error("stalled byte lost");

   c_tx_done:  cover property (txDoneEvt);
   c_rx_good:  cover property (rxDoneEvt ##1 crcOk);
   c_rx_bad:   cover property (rxDoneEvt ##1 !crcOk);
   c_cca_done: cover property (ccaDoneEvt);
   c_stall:    cover property (fifoCnt == 2'h2 && !modemTxReady);

endmodule

// ===== testbench/lwf_host_model.sv
// host controller model: spi frames towards the framer
`timescale 1ns/1ns

module lwf_host_model (
   // spi pins
   output logic      spiClk,
   output logic      spiSelN,
   output logic      spiMosi,
   input  wire logic spiMisoOut,
   input  wire logic spiMisoOe
);
   logic [7:0] txb [0:131];
   logic [7:0] rxb [0:131];

   // idle: deselected, clock low
   initial begin
      spiClk = 1'b0;
      spiSelN = 1'b1;
      spiMosi = 1'b0;
   end

   // one frame of n bytes; clock only runs inside the frame
   task automatic frame(input int n);
      spiSelN = 1'b0;
      #20;
      for (int i = 0; i < n; i++) begin
         for (int b = 7; b >= 0; b--) begin
            spiMosi = txb[i][b];
            #7 spiClk = 1'b1;
            // undriven miso reads as pulled high
            rxb[i][b] = spiMisoOe ? spiMisoOut : 1'b1;
            #8 spiClk = 1'b0;
         end
      end
      #8 spiSelN = 1'b1;
      spiMosi = ~spiMosi; // released line must not keep last bit
      #40;
   endtask
endmodule

// ===== testbench/lwf_framer_tb.sv
// self-checking bench of the low-rate packet framer
`timescale 1ns/1ns

module lwf_framer_tb;
   logic        core_clk, nrst, irqN;
   logic        spiClk, spiSelN, spiMosi, spiMisoOut, spiMisoOe;
   logic        modemTxValid, modemTxReady, modemRxValid;
   logic [7:0]  modemTxData, modemRxData, modemEnergy, e;
   logic [3:0]  modemChannel;
   logic [15:0] c;
   logic [7:0]  pay [$], txq [$], rxf [$];
   int          failures, n_compared, len;

   lwf_framer #(.LQI_CYCLES(40)) i_dut (.core_clk, .nrst, .spiClk,
      .spiSelN, .spiMosi, .spiMisoOut, .spiMisoOe, .irqN, .modemTxValid,
      .modemTxData, .modemTxReady, .modemRxValid, .modemRxData,
      .modemEnergy, .modemChannel);
   lwf_host_model i_host (.spiClk, .spiSelN, .spiMosi, .spiMisoOut,
      .spiMisoOe);

   // core clock, 8 ns
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // modem sink stalls at random; accepted bytes are logged
   always @(negedge core_clk) modemTxReady <= 1'(($urandom % 4) != 0);
   always @(posedge core_clk) begin
      if (modemTxValid && modemTxReady) txq.push_back(modemTxData);
   end

   task automatic chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic spi(input logic [7:0] a, b, input int n);
      i_host.txb[0] = a;
      i_host.txb[1] = b;
      i_host.frame(n);
   endtask

   // bounded wait for the interrupt line to go low
   task automatic wait_irq;
      for (int i = 0; i < 6000; i++) begin
         @(negedge core_clk);
         if (irqN === 1'b0) return;
      end
      failures++;
      $display("mismatch at %0t: no interrupt", $time);
      tally_and_finish;
   endtask

   // reflected crc, init zero, no final inversion
   function automatic logic [15:0] crc16(input logic [7:0] d [$]);
      logic [15:0] r = 16'h0000;
      foreach (d[i]) begin
         r ^= {8'h00, d[i]};
         repeat (8) r = r[0] ? (r >> 1) ^ 16'h8408 : r >> 1;
      end
      return r;
   endfunction

   initial begin
      {nrst, modemRxValid, modemRxData} = '0;
      modemEnergy = 8'h00;
      void'($urandom(37));
      repeat (5) @(negedge core_clk);
      chk(irqN, 1);
      chk(modemChannel, 0);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      e = 8'($urandom);
      spi(8'h01, {e[3:0], 4'h0}, 2);
      repeat (4) @(negedge core_clk);
      chk(modemChannel, e[3:0]);
      // packet transmit: longest payload first, then a short one
      for (int k = 0; k < 2; k++) begin
         len = k ? 1 + $urandom % 8 : 125;
         pay = {};
         for (int i = 0; i < len; i++) pay.push_back(8'($urandom));
         foreach (pay[i]) i_host.txb[i + 1] = pay[i];
         i_host.txb[0] = 8'h02;
         i_host.frame(len + 1);
         txq = {};
         spi(8'h03, 8'(len), 2);
         wait_irq;
         c = crc16(pay);
         chk(txq.size(), 8 + len);
         for (int i = 0; i < 4; i++) chk(txq[i], 8'h00);
         chk(txq[4], 8'hA7);
         chk(txq[5], len + 2);
         foreach (pay[i]) chk(txq[6 + i], pay[i]);
         chk({txq[len + 7], txq[len + 6]}, c);
         spi(8'h05, 8'h00, 3);
         chk(i_host.rxb[2][2], 1);
         $display("test packet tx of %0d bytes done", len);
      end
      // receive: good frame, broken fcs, then a good one in stream mode
      @(negedge core_clk);
      modemEnergy = e;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) begin
            spi(8'h01, {e[3:0], 4'h1}, 2);
         end
         len = 1 + $urandom % 8;
         pay = {};
         for (int i = 0; i < len; i++) pay.push_back(8'($urandom));
         c = crc16(pay) ^ 16'(k == 1);
         rxf = {8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'(len + 2)};
         rxf = {rxf, pay, c[7:0], c[15:8]};
         foreach (rxf[i]) begin
            @(negedge core_clk);
            modemRxData <= rxf[i];
            modemRxValid <= 1'b1;
            @(negedge core_clk);
            modemRxValid <= 1'b0;
            repeat (2) @(negedge core_clk);
         end
         wait_irq;
         spi(8'h05, 8'h00, 3);
         chk(i_host.rxb[2][0], 1);
         chk(i_host.rxb[2][1], 1'(k == 2));
         chk(i_host.rxb[2][5], 1'(k != 1));
         chk(irqN, 1);
         spi(8'h04, 8'h00, 130);
         chk(i_host.rxb[2], len + 2);
         foreach (pay[i]) chk(i_host.rxb[3 + i], pay[i]);
         chk({i_host.rxb[len + 4], i_host.rxb[len + 3]}, c);
         chk(i_host.rxb[129], e);
         $display("test rx %0d done", k);
      end
      // clear-channel level over constant energy, offset added
      spi(8'h06, 8'h00, 1);
      wait_irq;
      spi(8'h05, 8'h00, 3);
      chk(i_host.rxb[2][4], 1);
      spi(8'h07, 8'h00, 3);
      chk(i_host.rxb[2], e > 8'hF8 ? 8'hFF : e + 8'h07);
      $display("test cca done");
      // stream transmit: every word is asked for by an interrupt
      pay = {8'($urandom), 8'($urandom)};
      txq = {};
      spi(8'h03, 8'h02, 2);
      foreach (pay[i]) begin
         wait_irq;
         spi(8'h05, 8'h00, 3);
         chk(i_host.rxb[2][3], 1);
         spi(8'h08, pay[i], 2);
      end
      wait_irq;
      spi(8'h05, 8'h00, 3);
      chk(i_host.rxb[2][2], 1);
      chk(txq.size(), 10);
      chk(txq[5], 8'h04);
      chk(txq[6], pay[0]);
      chk(txq[7], pay[1]);
      chk({txq[9], txq[8]}, crc16(pay));
      $display("test stream tx done");
      tally_and_finish;
   end
endmodule
